// *** rtl/can_flag_bank.sv ***
// bank of sticky flags with set-wins clear
`timescale 1ns/1ps
module can_flag_bank #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // set condition and clear request per flag
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // flag state
  output logic [W-1:0] flag_out
);
  logic [W-1:0] flag_next;

  // per flag: condition holds keeps it set, clear only drops it otherwise
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        flag_next[i] = set_in[i] | (flag_out[i] & ~clr_in[i]);
      end
    end
  endgenerate

  // flag registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      flag_out <= RST;
    end else begin
      flag_out <= flag_next;
    end
  end
endmodule

// *** rtl/can_interrupt_and_recovery_ctrl.sv ***
// interrupt, flag, mode and bus-off recovery control of a CAN controller
`timescale 1ns/1ps
module can_interrupt_and_recovery_ctrl
  import can_irq_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // AXI4-Lite write address and data
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [7:0] AWADDR_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  // AXI4-Lite write response
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  output logic [1:0] BRESP_OUT,
  // AXI4-Lite read
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  input wire logic [7:0] ARADDR_IN,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  // CAN side events and error counters
  input wire can_evt_t CAN_EVT_IN,
  input wire err_cnt_t ERR_CNT_IN,
  // interrupt requests and bus status
  output irq_t IRQ_REQ_OUT,
  output logic IRQ_OUT,
  output logic BUS_OFF_OUT,
  output logic BUS_RECOVER_OUT,
  output logic ON_BUS_OUT
);
  localparam logic [7:0] RECOV_LAST = RECOV_CNT - 8'h01;

  // bus slave state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire, ar_fire, lane0, wr_hit, rd_hit, rd_evstat;
  logic we_ctrl0, we_ctrl1, we_rxflg, we_rxien, we_txflg, we_txien, we_misc, we_evmask;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] rd_data;
  // software control state
  logic init_request_reg, init_request_next, sleep_request_reg, sleep_request_next;
  logic wake_enable_reg, wake_enable_next, module_enable_reg, module_enable_next;
  logic recovery_sel_reg, recovery_sel_next;
  logic [NRXF-1:0] rx_ien_reg, rx_ien_next;
  logic [NTX-1:0] tx_ien_reg, tx_ien_next;
  logic [NEV-1:0] ev_mask_reg, ev_mask_next;
  // mode, bus state and recovery
  mode_t mode_reg, mode_next;
  bo_t bo_reg, bo_next;
  logic [7:0] recov_cnt_reg, recov_cnt_next;
  logic [1:0] tx_st_reg, tx_st_next, rx_st_reg, rx_st_next;
  logic init_ack, sleep_ack, wake_evt, rx_set, bsc_set, bo_enter, count_tick, hold_set;
  // flags and outputs
  logic [NRXF-1:0] rx_flag, rx_set_vec, rx_clr_vec;
  logic [NTX-1:0] tx_flag;
  logic [NEV-1:0] ev_flag;
  logic [0:0] hold_flag;
  irq_t irq_reg, irq_next;
  logic irq_any_reg, irq_any_next, bus_off_reg, bus_off_next;
  logic recover_reg, recover_next, on_bus_reg, on_bus_next;

  // map an error count onto its bus state range
  function automatic logic [1:0] err_range(input logic [8:0] cnt);
    logic [1:0] st;
    st = ST_OK;
    if (cnt >= ERR_BUSOFF) begin
      st = ST_BUSOFF;
    end else if (cnt >= ERR_PASSIVE) begin
      st = ST_PASSIVE;
    end else if (cnt >= ERR_WARN) begin
      st = ST_WARN;
    end
    return st;
  endfunction

  // AXI channel handshakes: address and data taken in either order
  always_comb begin
    wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    ar_fire = ARVALID_IN & arready_reg;
    aw_held_next = (aw_held_reg & ~wr_fire) | (AWVALID_IN & awready_reg);
    aw_addr_next = (AWVALID_IN & awready_reg) ? AWADDR_IN : aw_addr_reg;
    w_held_next = (w_held_reg & ~wr_fire) | (WVALID_IN & wready_reg);
    w_data_next = (WVALID_IN & wready_reg) ? WDATA_IN : w_data_reg;
    w_strb_next = (WVALID_IN & wready_reg) ? WSTRB_IN : w_strb_reg;
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
    bvalid_next = wr_fire | (bvalid_reg & ~BREADY_IN);
    bresp_next = bresp_reg;
    if (wr_fire) begin
      bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    rvalid_next = ar_fire | (rvalid_reg & ~RREADY_IN);
    arready_next = ~rvalid_next;
    rdata_next = ar_fire ? rd_data : rdata_reg;
    rresp_next = rresp_reg;
    if (ar_fire) begin
      rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // bus slave registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // write decode; every writable field sits in byte lane zero
  always_comb begin
    wr_addr = {aw_addr_reg[7:2], 2'b00};
    lane0 = wr_fire & w_strb_reg[0];
    wr_hit = 1'b1;
    we_ctrl0 = 1'b0;
    we_ctrl1 = 1'b0;
    we_rxflg = 1'b0;
    we_rxien = 1'b0;
    we_txflg = 1'b0;
    we_txien = 1'b0;
    we_misc = 1'b0;
    we_evmask = 1'b0;
    case (wr_addr)
      OFS_CTRL0: we_ctrl0 = lane0;
      OFS_CTRL1: we_ctrl1 = lane0;
      OFS_RXFLG: we_rxflg = lane0;
      OFS_RXIEN: we_rxien = lane0;
      OFS_TXFLG: we_txflg = lane0;
      OFS_TXIEN: we_txien = lane0;
      OFS_MISC: we_misc = lane0;
      OFS_EVSTAT: wr_hit = 1'b1; // read-only, write ignored
      OFS_EVMASK: we_evmask = lane0;
      default: wr_hit = 1'b0;
    endcase
  end

  // read multiplexer; reading event status clears it
  always_comb begin
    rd_addr = {ARADDR_IN[7:2], 2'b00};
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    rd_evstat = 1'b0;
    case (rd_addr)
      OFS_CTRL0: begin
        rd_data[C0_INIT_REQ] = init_request_reg;
        rd_data[C0_SLEEP_REQ] = sleep_request_reg;
        rd_data[C0_WAKE_EN] = wake_enable_reg;
        rd_data[C0_MOD_EN] = module_enable_reg;
        rd_data[C0_INIT_ACK] = init_ack;
        rd_data[C0_SLEEP_ACK] = sleep_ack;
        rd_data[C0_ON_BUS] = on_bus_reg;
      end
      OFS_CTRL1: rd_data[C1_BO_SEL] = recovery_sel_reg;
      OFS_RXFLG: begin
        rd_data[RF_RXF] = rx_flag[FL_RXF];
        rd_data[RF_OVR] = rx_flag[FL_OVR];
        rd_data[RF_TST +: 2] = tx_st_reg;
        rd_data[RF_RST +: 2] = rx_st_reg;
        rd_data[RF_BSC] = rx_flag[FL_BSC];
        rd_data[RF_WAKE] = rx_flag[FL_WAKE];
      end
      OFS_RXIEN: begin
        rd_data[RF_RXF] = rx_ien_reg[FL_RXF];
        rd_data[RF_OVR] = rx_ien_reg[FL_OVR];
        rd_data[RF_BSC] = rx_ien_reg[FL_BSC];
        rd_data[RF_WAKE] = rx_ien_reg[FL_WAKE];
      end
      OFS_TXFLG: rd_data[NTX-1:0] = tx_flag;
      OFS_TXIEN: rd_data[NTX-1:0] = tx_ien_reg;
      OFS_MISC: rd_data[MISC_HOLD] = hold_flag[0];
      OFS_EVSTAT: begin
        rd_data[NEV-1:0] = ev_flag;
        rd_evstat = ar_fire;
      end
      OFS_EVMASK: rd_data[NEV-1:0] = ev_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // software control bits; wake-up releases the sleep request
  always_comb begin
    init_request_next = init_request_reg;
    sleep_request_next = sleep_request_reg;
    wake_enable_next = wake_enable_reg;
    module_enable_next = module_enable_reg;
    recovery_sel_next = recovery_sel_reg;
    rx_ien_next = rx_ien_reg;
    tx_ien_next = tx_ien_reg;
    ev_mask_next = ev_mask_reg;
    if (we_ctrl0) begin
      init_request_next = w_data_reg[C0_INIT_REQ];
      sleep_request_next = w_data_reg[C0_SLEEP_REQ];
      wake_enable_next = w_data_reg[C0_WAKE_EN];
      module_enable_next = w_data_reg[C0_MOD_EN];
    end
    if (wake_evt) begin
      sleep_request_next = 1'b0;
    end
    if (we_ctrl1 & init_ack) begin
      recovery_sel_next = w_data_reg[C1_BO_SEL]; // writable in init mode only
    end
    if (we_rxien) begin
      rx_ien_next = {w_data_reg[RF_WAKE], w_data_reg[RF_BSC], w_data_reg[RF_OVR],
                     w_data_reg[RF_RXF]};
    end
    if (we_txien) begin
      tx_ien_next = w_data_reg[NTX-1:0];
    end
    if (we_evmask) begin
      ev_mask_next = w_data_reg[NEV-1:0];
    end
  end

  // control registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      init_request_reg <= INIT_REQ_RST;
      sleep_request_reg <= 1'b0;
      wake_enable_reg <= 1'b0;
      module_enable_reg <= 1'b0;
      recovery_sel_reg <= 1'b0;
      rx_ien_reg <= '0;
      tx_ien_reg <= '0;
      ev_mask_reg <= '0;
    end else begin
      init_request_reg <= init_request_next;
      sleep_request_reg <= sleep_request_next;
      wake_enable_reg <= wake_enable_next;
      module_enable_reg <= module_enable_next;
      recovery_sel_reg <= recovery_sel_next;
      rx_ien_reg <= rx_ien_next;
      tx_ien_reg <= tx_ien_next;
      ev_mask_reg <= ev_mask_next;
    end
  end

  // CAN events, bus state fields and request lines
  always_comb begin
    init_ack = (mode_reg == MD_INIT);
    sleep_ack = (mode_reg == MD_SLEEP);
    wake_evt = sleep_ack & wake_enable_reg & CAN_EVT_IN.bus_activity;
    rx_set = CAN_EVT_IN.rx_to_fg & ~sleep_ack;
    bo_enter = (bo_reg == BO_ACTIVE) & (ERR_CNT_IN.tx >= ERR_BUSOFF);
    tx_st_next = (bo_reg != BO_ACTIVE) ? ST_BUSOFF : err_range(ERR_CNT_IN.tx);
    rx_st_next = (bo_reg != BO_ACTIVE) ? ST_BUSOFF : err_range({1'b0, ERR_CNT_IN.rx});
    bsc_set = ((tx_st_next != tx_st_reg) & (tx_st_next != ST_OK)) |
              ((rx_st_next != rx_st_reg) & (rx_st_next != ST_OK));
    rx_set_vec = '0;
    rx_set_vec[FL_RXF] = rx_set;
    rx_set_vec[FL_OVR] = CAN_EVT_IN.rx_overrun;
    rx_set_vec[FL_BSC] = bsc_set;
    rx_set_vec[FL_WAKE] = wake_evt;
    rx_clr_vec = '0;
    if (we_rxflg) begin
      rx_clr_vec = {w_data_reg[RF_WAKE], w_data_reg[RF_BSC], w_data_reg[RF_OVR],
                    w_data_reg[RF_RXF]};
    end
    irq_next.wake = rx_flag[FL_WAKE] & rx_ien_reg[FL_WAKE];
    irq_next.err = (rx_flag[FL_BSC] & rx_ien_reg[FL_BSC]) |
                   (rx_flag[FL_OVR] & rx_ien_reg[FL_OVR]);
    irq_next.rx = rx_flag[FL_RXF] & rx_ien_reg[FL_RXF];
    irq_next.tx = |(tx_flag & tx_ien_reg);
    irq_any_next = |(ev_flag & ev_mask_reg);
  end

  // operating mode sequence
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MD_DISABLED: begin
        if (module_enable_reg) begin
          mode_next = init_request_reg ? MD_INIT : MD_RESYNC;
        end
      end
      MD_INIT: begin
        if (!init_request_reg) begin
          mode_next = MD_RESYNC;
        end
      end
      MD_RESYNC: begin
        if (init_request_reg) begin
          mode_next = MD_INIT;
        end else if (CAN_EVT_IN.recessive11) begin
          mode_next = MD_NORMAL;
        end
      end
      MD_NORMAL: begin
        if (init_request_reg & CAN_EVT_IN.bus_idle) begin
          mode_next = MD_INIT;
        end else if (sleep_request_reg & (&tx_flag) & CAN_EVT_IN.bus_idle) begin
          mode_next = MD_SLEEP;
        end
      end
      MD_SLEEP: begin
        if (init_request_reg) begin
          mode_next = MD_INIT;
        end else if (wake_evt | ~sleep_request_reg) begin
          mode_next = MD_RESYNC;
        end
      end
      default: mode_next = MD_DISABLED;
    endcase
    if (!module_enable_reg) begin
      mode_next = MD_DISABLED;
    end
    on_bus_next = (mode_next == MD_NORMAL);
  end

  // bus-off recovery; counting pauses while asleep
  always_comb begin
    bo_next = bo_reg;
    recov_cnt_next = recov_cnt_reg;
    count_tick = CAN_EVT_IN.recessive11 & ~sleep_ack;
    hold_set = bo_enter & recovery_sel_reg;
    unique case (bo_reg)
      BO_ACTIVE: begin
        if (bo_enter) begin
          bo_next = BO_COUNT;
          recov_cnt_next = 8'h00;
        end
      end
      BO_COUNT: begin
        if (count_tick) begin
          if (recov_cnt_reg == RECOV_LAST) begin
            bo_next = (recovery_sel_reg & hold_flag[0]) ? BO_WAIT : BO_RECOVER;
          end else begin
            recov_cnt_next = recov_cnt_reg + 8'h01;
          end
        end
      end
      BO_WAIT: begin
        if (!hold_flag[0]) begin
          bo_next = BO_RECOVER;
        end
      end
      BO_RECOVER: bo_next = BO_ACTIVE;
    endcase
    bus_off_next = (bo_next == BO_COUNT) | (bo_next == BO_WAIT);
    recover_next = (bo_next == BO_RECOVER);
  end

  // mode, recovery, field and output registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      mode_reg <= MD_DISABLED;
      bo_reg <= BO_ACTIVE;
      recov_cnt_reg <= 8'h00;
      tx_st_reg <= ST_OK;
      rx_st_reg <= ST_OK;
      irq_reg <= '0;
      irq_any_reg <= 1'b0;
      bus_off_reg <= 1'b0;
      recover_reg <= 1'b0;
      on_bus_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      bo_reg <= bo_next;
      recov_cnt_reg <= recov_cnt_next;
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      irq_reg <= irq_next;
      irq_any_reg <= irq_any_next;
      bus_off_reg <= bus_off_next;
      recover_reg <= recover_next;
      on_bus_reg <= on_bus_next;
    end
  end

  // receiver flags: wake, status change, overrun, receive full
  can_flag_bank #(.W(NRXF), .RST(RXF_RST)) u_rx_flags (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .set_in(rx_set_vec),
    .clr_in(rx_clr_vec),
    .flag_out(rx_flag)
  );

  // transmit buffer empty flags
  can_flag_bank #(.W(NTX), .RST(TXF_RST)) u_tx_flags (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .set_in(CAN_EVT_IN.tx_empty),
    .clr_in({NTX{we_txflg}} & w_data_reg[NTX-1:0]),
    .flag_out(tx_flag)
  );

  // bus-off hold bit, set on entry in user mode, cleared by writing one
  can_flag_bank #(.W(1), .RST(HOLD_RST)) u_hold (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .set_in(hold_set),
    .clr_in(we_misc & w_data_reg[MISC_HOLD]),
    .flag_out(hold_flag)
  );

  // sticky event status: rising request lines, cleared by reading
  can_flag_bank #(.W(NEV), .RST(EV_RST)) u_events (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .set_in(irq_next & ~irq_reg),
    .clr_in({NEV{rd_evstat}}),
    .flag_out(ev_flag)
  );

  // outputs straight from flip-flops
  assign AWREADY_OUT = awready_reg;
  assign WREADY_OUT = wready_reg;
  assign BVALID_OUT = bvalid_reg;
  assign BRESP_OUT = bresp_reg;
  assign ARREADY_OUT = arready_reg;
  assign RVALID_OUT = rvalid_reg;
  assign RDATA_OUT = rdata_reg;
  assign RRESP_OUT = rresp_reg;
  assign IRQ_REQ_OUT = irq_reg;
  assign IRQ_OUT = irq_any_reg;
  assign BUS_OFF_OUT = bus_off_reg;
  assign BUS_RECOVER_OUT = recover_reg;
  assign ON_BUS_OUT = on_bus_reg;
endmodule

// *** rtl/can_irq_pkg.sv ***
// constants and types shared by the interrupt and recovery controller
package can_irq_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RXFLG = 8'h08;
  localparam logic [7:0] OFS_RXIEN = 8'h0c;
  localparam logic [7:0] OFS_TXFLG = 8'h10;
  localparam logic [7:0] OFS_TXIEN = 8'h14;
  localparam logic [7:0] OFS_MISC = 8'h18;
  localparam logic [7:0] OFS_EVSTAT = 8'h1c;
  localparam logic [7:0] OFS_EVMASK = 8'h20;
  // control register zero bit positions
  localparam int C0_INIT_REQ = 0;
  localparam int C0_SLEEP_REQ = 1;
  localparam int C0_WAKE_EN = 2;
  localparam int C0_MOD_EN = 7;
  localparam int C0_INIT_ACK = 8;
  localparam int C0_SLEEP_ACK = 9;
  localparam int C0_ON_BUS = 10;
  // control register one and misc register bit positions
  localparam int C1_BO_SEL = 0;
  localparam int MISC_HOLD = 0;
  // rx flag and rx enable register bit positions
  localparam int RF_RXF = 0;
  localparam int RF_OVR = 1;
  localparam int RF_TST = 2;
  localparam int RF_RST = 4;
  localparam int RF_BSC = 6;
  localparam int RF_WAKE = 7;
  // index of each rx flag inside the flag bank
  localparam int FL_RXF = 0;
  localparam int FL_OVR = 1;
  localparam int FL_BSC = 2;
  localparam int FL_WAKE = 3;
  localparam int NRXF = 4;
  localparam int NTX = 3;
  localparam int NEV = 4;
  // reset values
  localparam logic INIT_REQ_RST = 1'b1;
  localparam logic [NTX-1:0] TXF_RST = 3'h7;
  localparam logic [NRXF-1:0] RXF_RST = 4'h0;
  localparam logic [NEV-1:0] EV_RST = 4'h0;
  localparam logic [0:0] HOLD_RST = 1'h0;
  // error counter ranges and bus-off recovery count
  localparam logic [8:0] ERR_WARN = 9'h060;
  localparam logic [8:0] ERR_PASSIVE = 9'h080;
  localparam logic [8:0] ERR_BUSOFF = 9'h100;
  localparam logic [7:0] RECOV_CNT = 8'h80;
  // bus state field encodings
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_PASSIVE = 2'h2;
  localparam logic [1:0] ST_BUSOFF = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MD_DISABLED = 3'b000,
    MD_INIT = 3'b001,
    MD_RESYNC = 3'b010,
    MD_NORMAL = 3'b011,
    MD_SLEEP = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    BO_ACTIVE = 2'b00,
    BO_COUNT = 2'b01,
    BO_WAIT = 2'b10,
    BO_RECOVER = 2'b11
  } bo_t;

  typedef struct packed {
    logic [2:0] tx_empty;
    logic rx_to_fg;
    logic rx_overrun;
    logic bus_activity;
    logic recessive11;
    logic bus_idle;
  } can_evt_t;

  typedef struct packed {
    logic [8:0] tx;
    logic [7:0] rx;
  } err_cnt_t;

  typedef struct packed {
    logic wake;
    logic err;
    logic rx;
    logic tx;
  } irq_t;
endpackage

// *** tb/can_bus_node.sv ***
// CAN bus side model raising events and error counts
`timescale 1ns/1ps
module can_bus_node
  import can_irq_pkg::*;
(
  // clock, events and error counts
  input wire logic clk_in,
  output can_evt_t evt_out,
  output err_cnt_t err_out
);
  logic [7:0] lvl = 8'h00;
  // quiet bus at start
  initial begin
    evt_out = '0;
    err_out = '0;
  end
  // one-cycle event on top of held levels
  task automatic pulse(input logic [7:0] p);
    @(posedge clk_in);
    evt_out <= can_evt_t'(p | lvl);
    @(posedge clk_in);
    evt_out <= can_evt_t'(lvl);
  endtask
  // held conditions such as an overrun that persists
  task automatic level(input logic [7:0] l);
    lvl = l;
    @(posedge clk_in);
    evt_out <= can_evt_t'(l);
  endtask
  task automatic errs(input logic [16:0] e);
    @(posedge clk_in);
    err_out <= err_cnt_t'(e);
  endtask
endmodule

// *** tb/can_interrupt_and_recovery_ctrl_tb.sv ***
// self-checking bench of the interrupt and recovery controller
`timescale 1ns/1ps
module can_interrupt_and_recovery_ctrl_tb
  import can_irq_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic rready = 1'b0, awr, wrd, bv, arr, rv, irq_o, bo, brec, onb;
  logic [7:0] awa = 8'h00, ara = 8'h00, lf = 8'h40;
  logic [31:0] wd = 32'h0, rdat, rd_d;
  logic [1:0] br, rr, rd_r, wr_r;
  logic [3:0] strb = 4'hf;
  irq_t irq;
  can_evt_t evt;
  err_cnt_t err;
  int bad_count = 0, n_checks = 0, rec_seen = 0, tx_m = 7, rx_m = 0, ten = 0, ren = 0;
  can_interrupt_and_recovery_ctrl i_dut (.CLK_IN(clk), .RSTN_IN(rstn), .AWVALID_IN(awv),
    .AWREADY_OUT(awr), .AWADDR_IN(awa), .WVALID_IN(wv), .WREADY_OUT(wrd), .WDATA_IN(wd),
    .WSTRB_IN(strb), .BVALID_OUT(bv), .BREADY_IN(bready), .BRESP_OUT(br),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .ARADDR_IN(ara), .RVALID_OUT(rv),
    .RREADY_IN(rready), .RDATA_OUT(rdat), .RRESP_OUT(rr), .CAN_EVT_IN(evt),
    .ERR_CNT_IN(err), .IRQ_REQ_OUT(irq), .IRQ_OUT(irq_o), .BUS_OFF_OUT(bo),
    .BUS_RECOVER_OUT(brec), .ON_BUS_OUT(onb));
  can_bus_node i_node (.clk_in(clk), .evt_out(evt), .err_out(err));
  // clock and a counter of recovery pulses
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (brec === 1'b1) rec_seen++;
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus write: both channels offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    wr_r = br;
    bready <= 1'b0;
  endtask
  // bus read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd_d = rdat;
    rd_r = rr;
    rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t pins %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_rd(rd_d, exp);
  endtask
  // expected requests from the flag and enable model
  function automatic logic [3:0] irq_m();
    return {rx_m[7] & ren[7], (rx_m[6] & ren[6]) | (rx_m[1] & ren[1]), rx_m[0] & ren[0],
      |(tx_m & ten)};
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    idle(20000);
    bad_count++;
    $display("[ERR] %0t watchdog", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    idle(3);
    rstn <= 1'b1;
    rdc(OFS_CTRL0, 32'h1);
    rdc(OFS_TXFLG, 32'h7);
    rdc(8'h40, 32'h0);
    chk_pin({2'b00, rd_r}, {2'b00, RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk_pin({2'b00, wr_r}, {2'b00, RESP_SLVERR});
    $display("test reset done");
    wr(OFS_CTRL0, 32'h81);
    rdc(OFS_CTRL0, 32'h181);
    wr(OFS_CTRL1, 32'h1);
    wr(OFS_CTRL0, 32'h80);
    chk_pin({3'b000, onb}, 4'h0);
    i_node.pulse(8'h02);
    idle(3);
    chk_pin({3'b000, onb}, 4'h1);
    $display("test mode done");
    ten = 7;
    wr(OFS_TXIEN, 32'h7);
    idle(2);
    chk_pin(irq, irq_m());
    wr(OFS_TXFLG, 32'h2);
    tx_m = 5;
    rdc(OFS_TXFLG, tx_m);
    wr(OFS_TXFLG, 32'h5);
    tx_m = 0;
    idle(2);
    chk_pin(irq, irq_m());
    rd(OFS_EVSTAT);
    wr(OFS_EVMASK, 32'h1);
    i_node.pulse(8'h40);
    tx_m = 2;
    idle(3);
    chk_pin(irq, irq_m());
    chk_pin({3'b000, irq_o}, 4'h1);
    rdc(OFS_EVSTAT, 32'h1);
    idle(3);
    chk_pin({3'b000, irq_o}, 4'h0);
    i_node.pulse(8'he0);
    tx_m = 7;
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      wr(OFS_TXFLG, {29'h0, lf[2:0]});
      tx_m = tx_m & ~int'(lf[2:0]);
      rdc(OFS_TXFLG, tx_m);
    end
    $display("test tx done");
    ren = 'h43;
    wr(OFS_RXIEN, 32'h43);
    i_node.pulse(8'h10);
    rx_m = 1;
    idle(2);
    chk_pin(irq, irq_m());
    wr(OFS_RXFLG, 32'h1);
    rdc(OFS_RXFLG, 32'h0);
    i_node.pulse(8'h10);
    rdc(OFS_RXFLG, rx_m);
    i_node.level(8'h08);
    rx_m = 3;
    idle(3);
    chk_pin(irq, irq_m());
    wr(OFS_RXFLG, 32'h2);
    rdc(OFS_RXFLG, rx_m);
    i_node.level(8'h00);
    wr(OFS_RXFLG, 32'h3);
    rx_m = 0;
    rdc(OFS_RXFLG, rx_m);
    $display("test rx done");
    i_node.errs(17'h00080);
    idle(2);
    rx_m = 'h40;
    rdc(OFS_RXFLG, 32'h60);
    i_node.errs(17'h10080);
    idle(3);
    rdc(OFS_RXFLG, 32'h7c);
    rdc(OFS_MISC, 32'h1);
    i_node.errs(17'h0);
    wr(OFS_MISC, 32'h1);
    repeat (127) i_node.pulse(8'h02);
    idle(3);
    chk_pin({bo, 3'(rec_seen)}, 4'h8);
    i_node.pulse(8'h02);
    idle(4);
    chk_pin({bo, 3'(rec_seen)}, 4'h1);
    rdc(OFS_RXFLG, rx_m);
    chk_pin(irq, irq_m());
    $display("test bus-off done");
    ren = 'hc3;
    wr(OFS_RXIEN, 32'hc3);
    i_node.level(8'h01);
    i_node.pulse(8'he0);
    tx_m = 7;
    wr(OFS_CTRL0, 32'h86);
    rdc(OFS_CTRL0, 32'h286);
    i_node.pulse(8'h04);
    rx_m = 'hc0;
    idle(2);
    chk_pin(irq, irq_m());
    rdc(OFS_CTRL0, 32'h84);
    strb <= 4'he;
    wr(OFS_RXFLG, 32'hc0);
    strb <= 4'hf;
    chk_pin({2'b00, wr_r}, {2'b00, RESP_OKAY});
    rdc(OFS_RXFLG, rx_m);
    i_node.pulse(8'h02);
    idle(3);
    chk_pin({3'b000, onb}, 4'h1);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule

// *** tb/can_irq_ctrl_asserts.sv ***
// port assertions of the interrupt and recovery controller
`timescale 1ns/1ps
module can_irq_ctrl_asserts
  import can_irq_pkg::*;
(
  // clock, reset, bus handshakes and bus-off status
  input wire logic CLK_IN, RSTN_IN, AWVALID_IN, AWREADY_OUT, WVALID_IN, WREADY_OUT,
  input wire logic BVALID_OUT, BREADY_IN, ARVALID_IN, ARREADY_OUT, RVALID_OUT,
  input wire logic RREADY_IN, BUS_OFF_OUT, BUS_RECOVER_OUT,
  // interrupt requests
  input wire irq_t IRQ_REQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // both write channels taken, slots busy, then the response
  sequence s_wr_take;
    AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
  endsequence
  sequence s_wr_resp;
    ##1 (!AWREADY_OUT && !WREADY_OUT) ##1 BVALID_OUT;
  endsequence
  AST_WR_LAT: assert property (s_wr_take |-> s_wr_resp)
    else $error("write response late");
  AST_B_HOLD: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
    else $error("write response dropped");
  AST_RD_LAT: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT && !ARREADY_OUT)
    else $error("read data late");
  AST_R_HOLD: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT)
    else $error("read data dropped");
  AST_R_DONE: assert property (RVALID_OUT && RREADY_IN |=> !RVALID_OUT)
    else $error("read data held");
  AST_REQ_FALL: assert property (|($past(IRQ_REQ_OUT) & ~IRQ_REQ_OUT) |->
    BVALID_OUT || $past(BVALID_OUT)) else $error("request fell without write");
  AST_RECOV_PULSE: assert property (BUS_RECOVER_OUT |=> !BUS_RECOVER_OUT)
    else $error("recovery pulse too long");
  AST_RECOV_BO: assert property (BUS_RECOVER_OUT |-> $past(BUS_OFF_OUT))
    else $error("recovery outside bus-off");
endmodule
bind can_interrupt_and_recovery_ctrl can_irq_ctrl_asserts i_chk (.CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN), .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT),
  .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT), .BVALID_OUT(BVALID_OUT),
  .BREADY_IN(BREADY_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
  .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .BUS_OFF_OUT(BUS_OFF_OUT),
  .BUS_RECOVER_OUT(BUS_RECOVER_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT));
